// >>> core/dcts_fifo.sv
// Small synchronous request FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dcts_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic sys_clk,          // System clock
  input wire logic reset,            // Synchronous reset
  input wire logic in_valid,         // Write side valid
  output logic in_ready,             // Write side ready
  input wire logic [W-1:0] in_data,  // Write data
  output logic out_valid,            // Read side valid
  input wire logic out_ready,        // Read side ready
  output logic [W-1:0] out_data      // Read data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dcts_fifo_state_type;
  dcts_fifo_state_type r, r_nxt;
  logic push;
  logic pop;
  // Handshakes from fill level
  assign in_ready = (r.cnt != (AW+1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Pointer and storage update
  always_comb begin
    r_nxt = r;
    if (push) begin
      r_nxt.mem[r.wp] = in_data;
      r_nxt.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      r_nxt.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
    end
    r_nxt.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (reset) begin
      r_nxt = '0;
    end
  end
  // State register
  always_ff @(posedge sys_clk) begin
    r <= r_nxt;
  end
endmodule
`default_nettype wire

// >>> core/dcts_link.sv
// Bus clock side: paces one cycle per command and hands back completion
`timescale 1ns/1ps
`default_nettype none
module dcts_link (
  input wire logic bclk,                 // Bus clock
  input wire logic reset,                // Reset from system domain
  input wire logic req_tgl,              // Command toggle, system domain
  input wire dcts_pkg::dcts_cmd_type cmd, // Command, held while pending
  output logic ack_tgl,                  // Completion toggle
  output logic bus_cyc_active,           // Cycle in progress
  output logic bus_io_phase,             // I/O portion of cycle
  output logic [3:0] bus_lanes,          // Byte lanes of cycle
  output logic [1:0] bus_timing          // Timing of cycle
);
  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] req_s;
    logic req_seen;
    logic ack;
    logic busy;
    logic io;
    logic [3:0] cnt;
    logic [3:0] io_cnt;
    dcts_pkg::dcts_cmd_type cmd;
  } dcts_link_state_type;
  dcts_link_state_type r, r_nxt;
  assign ack_tgl = r.ack;
  assign bus_cyc_active = r.busy;
  assign bus_io_phase = r.io;
  assign bus_lanes = r.cmd.lanes;
  assign bus_timing = r.cmd.timing;
  // Count out each cycle in bus clocks
  always_comb begin
    r_nxt = r;
    r_nxt.rst_s = {r.rst_s[0], reset};
    r_nxt.req_s = {r.req_s[0], req_tgl};
    if (r.busy) begin
      r_nxt.io = (r.io_cnt > 4'h1);
      r_nxt.io_cnt = (r.io_cnt != 4'h0) ? r.io_cnt - 4'h1 : 4'h0;
      if (r.cnt == 4'h0) begin
        r_nxt.busy = 1'b0;
        r_nxt.io = 1'b0;
        r_nxt.ack = ~r.ack;
      end else begin
        r_nxt.cnt = r.cnt - 4'h1;
      end
    end else if (r.req_s[1] != r.req_seen) begin
      r_nxt.req_seen = r.req_s[1];
      r_nxt.cmd = cmd;
      r_nxt.busy = 1'b1;
      r_nxt.io = 1'b1;
      r_nxt.cnt = cmd.total - 4'h1;
      r_nxt.io_cnt = cmd.io;
    end
    if (r.rst_s[1]) begin
      r_nxt = '0;
      r_nxt.rst_s = {r.rst_s[0], reset};
      r_nxt.req_s = {r.req_s[0], req_tgl};
    end
  end
  // State register
  always_ff @(posedge bclk) begin
    r <= r_nxt;
  end
endmodule
`default_nettype wire

// >>> core/dcts_top.sv
// Per-channel DMA cycle timing selection and cycle pacing
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Two-bit timing selector per channel, four codes
// [R2] Reset puts every selector at compatible
// [R3] ISA memory target forces compatible, per cycle
// [R4] Software picks compatible for slow ISA slaves
// [R5] Compatible: nine single, eight repeated clocks
// [R6] Type A: seven single, six repeated clocks
// [R7] Type A keeps compatible I/O portion
// [R8] Type B: six single, four repeated clocks
// [R9] Type B only toward EISA memory
// [R10] Burst slave watches ready and strobes; the slave model watches only the active and I/O strobes
// [R11] Burst lanes follow programmed data size
// [R12] Non-burst memory gets two-clock cycles
// [R13] Started non-burst stays non-burst whole transfer
// [R14] Low two bits select channel, six stored
// [R15] Cascade channel has no extended settings
// [R16] Each channel keeps and applies own timing
module dcts_top (
  input wire logic sys_clk,                 // System clock, 200 MHz
  input wire logic reset,                   // Synchronous reset, high
  input wire logic bclk,                    // Bus clock
  input wire logic emr_wr,                  // Extended mode write strobe
  input wire logic emr_hi_group,            // Write targets channels 4-7
  input wire logic [7:0] emr_wr_data,       // Extended mode write data
  input wire logic req_valid,               // Cycle request valid
  output logic req_ready,                   // Cycle request accepted
  input wire dcts_pkg::dcts_req_type req,   // Cycle request
  output logic [7:0][1:0] timing_sel,       // Stored timing per channel
  output logic [7:0][1:0] size_sel,         // Stored data size per channel
  output logic cyc_busy,                    // Cycle handed to bus side
  output logic cyc_done,                    // Cycle finished pulse
  output dcts_pkg::dcts_cmd_type cyc_cmd,   // Cycle command in use
  output logic bus_cyc_active,              // Bus clock: cycle running
  output logic bus_io_phase,                // Bus clock: I/O portion
  output logic [3:0] bus_lanes,             // Bus clock: byte lanes
  output logic [1:0] bus_timing             // Bus clock: timing used
);

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } dcts_state_type;

  // Whole state of this module
  typedef struct packed {
    logic [7:0][5:0] emr;
    dcts_state_type state;
    logic lock;
    logic req_tgl;
    logic [1:0] ack_s;
    logic ack_seen;
    logic done_p;
    dcts_pkg::dcts_cmd_type cmd;
  } dcts_top_state_type;

  dcts_top_state_type r, r_nxt;

  // Buffered request stream
  dcts_pkg::dcts_req_type q_req;
  logic q_valid;
  logic q_ready;
  logic ack_tgl;
  logic [2:0] wr_ch;

  // Byte lanes natural to a data size
  function automatic logic [3:0] lanes_of(input logic [1:0] sz);
    logic [3:0] l;
    l = 4'h1;
    case (sz)
      dcts_pkg::SZ_8_BYTES: l = 4'h1;
      dcts_pkg::SZ_16_WORDS: l = 4'h3;
      dcts_pkg::SZ_16_BYTES: l = 4'h3;
      dcts_pkg::SZ_32_BYTES: l = 4'hf;
      default: l = 4'h1;
    endcase
    return l;
  endfunction

  // Timing field of a stored setting
  function automatic logic [1:0] tim_of(input logic [5:0] e);
    return e[dcts_pkg::FLD_TIM_LSB +: 2];
  endfunction

  // Size field of a stored setting
  function automatic logic [1:0] size_of(input logic [5:0] e);
    return e[dcts_pkg::FLD_SIZE_LSB +: 2];
  endfunction

  // Cycle length for a timing and single or repeat
  function automatic logic [3:0] len_of(
    input logic [1:0] tm,
    input logic rpt
  );
    logic [3:0] n;
    n = dcts_pkg::COMPAT_SINGLE;
    case (tm)
      dcts_pkg::TM_COMPAT: begin
        n = rpt ? dcts_pkg::COMPAT_REPEAT // [R5]
                : dcts_pkg::COMPAT_SINGLE; // [R5]
      end
      dcts_pkg::TM_TYPE_A: begin
        n = rpt ? dcts_pkg::TYPE_A_REPEAT // [R6]
                : dcts_pkg::TYPE_A_SINGLE; // [R6]
      end
      dcts_pkg::TM_TYPE_B: begin
        n = rpt ? dcts_pkg::TYPE_B_REPEAT // [R8]
                : dcts_pkg::TYPE_B_SINGLE; // [R8]
      end
      default: begin
        n = dcts_pkg::BURST_BCLKS;
      end
    endcase
    return n;
  endfunction

  // I/O portion length for a timing
  function automatic logic [3:0] io_of(input logic [1:0] tm);
    logic [3:0] n;
    n = dcts_pkg::IO_FULL_BCLKS;
    case (tm)
      dcts_pkg::TM_COMPAT: n = dcts_pkg::IO_FULL_BCLKS;
      dcts_pkg::TM_TYPE_A: n = dcts_pkg::IO_FULL_BCLKS; // [R7]
      dcts_pkg::TM_TYPE_B: n = dcts_pkg::IO_SHORT_BCLKS;
      default: n = dcts_pkg::IO_BURST_BCLKS;
    endcase
    return n;
  endfunction

  // Request buffer between arbiter and sequencer
  dcts_fifo #(
    .W($bits(dcts_pkg::dcts_req_type)),
    .D(dcts_pkg::REQ_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_req)
  );

  // Bus clock side pacing
  dcts_link u_link (
    .bclk(bclk),
    .reset(reset),
    .req_tgl(r.req_tgl),
    .cmd(r.cmd),
    .ack_tgl(ack_tgl),
    .bus_cyc_active(bus_cyc_active),
    .bus_io_phase(bus_io_phase),
    .bus_lanes(bus_lanes),
    .bus_timing(bus_timing)
  );

  // Only take a request when no cycle is outstanding
  assign q_ready = (r.state == ST_IDLE);

  // Channel addressed by an extended mode write
  assign wr_ch = {emr_hi_group, emr_wr_data[dcts_pkg::EMR_SEL_MSB:0]}; // [R14]

  // Per-channel stored fields out
  genvar g;
  generate
    for (g = 0; g < dcts_pkg::NUM_CH; g = g + 1) begin : g_ch
      assign timing_sel[g] = tim_of(r.emr[g]); // [R1] [R16]
      assign size_sel[g] = size_of(r.emr[g]);
    end
  endgenerate

  // Status outputs
  assign cyc_busy = (r.state == ST_BUSY);
  assign cyc_done = r.done_p;
  assign cyc_cmd = r.cmd;

  // Next state
  always_comb begin
    logic [5:0] e;
    logic [1:0] tm;
    logic lock_now;
    e = '0;
    tm = dcts_pkg::TM_COMPAT;
    lock_now = 1'b0;
    r_nxt = r;
    r_nxt.done_p = 1'b0;
    // Completion toggle from bus side, two stages
    r_nxt.ack_s = {r.ack_s[0], ack_tgl};

    // Extended mode write; select bits are not kept
    if (emr_wr && (wr_ch != dcts_pkg::CASCADE_CH)) begin // [R15]
      r_nxt.emr[wr_ch] =
        emr_wr_data[dcts_pkg::EMR_STORE_MSB:dcts_pkg::EMR_STORE_LSB]; // [R14]
    end

    case (r.state)
      ST_IDLE: begin
        if (q_valid) begin
          e = r.emr[q_req.ch]; // [R16]
          tm = tim_of(e);
          // Non-burst lock decided at the first cycle
          lock_now = q_req.first ? ~q_req.burst_mem : r.lock; // [R13]
          r_nxt.lock = lock_now;
          if (q_req.isa_mem && (tm != dcts_pkg::TM_COMPAT)) begin
            // Fast timings toward ISA memory fall back
            tm = dcts_pkg::TM_COMPAT; // [R3] [R9]
          end
          r_nxt.cmd.timing = tm;
          r_nxt.cmd.total = len_of(tm, q_req.rpt);
          r_nxt.cmd.io = io_of(tm);
          r_nxt.cmd.lanes = lanes_of(size_of(e));
          if (tm == dcts_pkg::TM_BURST) begin
            // Burst lanes from the programmed size
            r_nxt.cmd.lanes = lanes_of(size_of(e)); // [R11]
            if (lock_now || !q_req.burst_mem) begin
              r_nxt.cmd.total = dcts_pkg::NONBURST_BCLKS; // [R12] [R13]
            end
          end
          r_nxt.req_tgl = ~r.req_tgl;
          r_nxt.state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (r.ack_s[1] != r.ack_seen) begin
          r_nxt.ack_seen = r.ack_s[1];
          r_nxt.done_p = 1'b1;
          r_nxt.state = ST_IDLE;
        end
      end
      default: begin
        r_nxt.state = ST_IDLE;
      end
    endcase

    // Reset values, compatible timing everywhere
    if (reset) begin
      r_nxt = '0;
      r_nxt.state = ST_IDLE;
      for (int i = 0; i < dcts_pkg::NUM_CH; i++) begin
        r_nxt.emr[i] = (i < 4) ? dcts_pkg::EMR_RST_LO // [R2]
                               : dcts_pkg::EMR_RST_HI; // [R2]
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    r <= r_nxt;
  end

endmodule
`default_nettype wire

// >>> pkg/dcts_pkg.sv
// Shared constants and carrier types for DMA cycle timing selection
package dcts_pkg;
  // Timing selector encodings
  localparam logic [1:0] TM_COMPAT = 2'h0;
  localparam logic [1:0] TM_TYPE_A = 2'h1;
  localparam logic [1:0] TM_TYPE_B = 2'h2;
  localparam logic [1:0] TM_BURST = 2'h3;
  // Data size encodings
  localparam logic [1:0] SZ_8_BYTES = 2'h0;
  localparam logic [1:0] SZ_16_WORDS = 2'h1;
  localparam logic [1:0] SZ_32_BYTES = 2'h2;
  localparam logic [1:0] SZ_16_BYTES = 2'h3;
  // Channel layout
  localparam int NUM_CH = 8;
  localparam logic [2:0] CASCADE_CH = 3'h4;
  // Extended mode write layout and stored field positions
  localparam int EMR_SEL_MSB = 1;
  localparam int EMR_STORE_LSB = 2;
  localparam int EMR_STORE_MSB = 7;
  localparam int FLD_SIZE_LSB = 0;
  localparam int FLD_TIM_LSB = 2;
  // Stored values after reset, low and high channel groups
  localparam logic [5:0] EMR_RST_LO = 6'h00;
  localparam logic [5:0] EMR_RST_HI = 6'h01;
  // Cycle lengths in bus clocks
  localparam logic [3:0] COMPAT_SINGLE = 4'h9;
  localparam logic [3:0] COMPAT_REPEAT = 4'h8;
  localparam logic [3:0] TYPE_A_SINGLE = 4'h7;
  localparam logic [3:0] TYPE_A_REPEAT = 4'h6;
  localparam logic [3:0] TYPE_B_SINGLE = 4'h6;
  localparam logic [3:0] TYPE_B_REPEAT = 4'h4;
  localparam logic [3:0] BURST_BCLKS = 4'h1;
  localparam logic [3:0] NONBURST_BCLKS = 4'h2;
  // I/O portion of a cycle in bus clocks
  localparam logic [3:0] IO_FULL_BCLKS = 4'h3;
  localparam logic [3:0] IO_SHORT_BCLKS = 4'h2;
  localparam logic [3:0] IO_BURST_BCLKS = 4'h1;
  // Request buffer depth
  localparam int REQ_FIFO_DEPTH = 4;
  // One cycle request from the arbiter side
  typedef struct packed {
    logic [2:0] ch;      // Requesting channel
    logic rpt;           // Repeated block or transfer_mode_a cycle
    logic isa_mem;       // Target memory sits on the ISA bus
    logic burst_mem;     // Target memory accepts burst
    logic first;         // First cycle of a transfer
  } dcts_req_type;
  // One cycle command toward the bus clock side
  typedef struct packed {
    logic [1:0] timing;  // Timing actually used
    logic [3:0] total;   // Cycle length in bus clocks
    logic [3:0] io;      // I/O portion in bus clocks
    logic [3:0] lanes;   // Byte lanes in use
  } dcts_cmd_type;
endpackage

// >>> tb/dcts_monitor.sv
// Port checker for the timing selection block
`timescale 1ns/1ps
`default_nettype none
module dcts_monitor (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic bclk, // Bus clock
  input wire logic emr_wr, // Write strobe
  input wire logic emr_hi_group, // Upper group
  input wire logic [7:0] emr_wr_data, // Write data
  input wire logic [7:0][1:0] timing_sel, // Stored timing
  input wire logic [7:0][1:0] size_sel, // Stored size
  input wire logic cyc_busy, // Cycle handed off
  input wire logic cyc_done, // Cycle finished
  input wire dcts_pkg::dcts_cmd_type cyc_cmd, // Command in use
  input wire logic bus_cyc_active, // Bus cycle running
  input wire logic bus_io_phase // Bus I/O portion
);
  logic [2:0] wch_r;
  logic [5:0] wdat_r;
  // Last write target and stored bits
  always_ff @(posedge sys_clk) begin
    wch_r <= {emr_hi_group, emr_wr_data[1:0]};
    wdat_r <= emr_wr_data[7:2];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_write_stored: assert property (
    emr_wr && ({emr_hi_group, emr_wr_data[1:0]} != dcts_pkg::CASCADE_CH) |=>
    timing_sel[wch_r] == wdat_r[3:2] && size_sel[wch_r] == wdat_r[1:0])
    else $error("stored setting differs from write");
  chk_cascade_fixed: assert property (
    timing_sel[4] == dcts_pkg::TM_COMPAT && size_sel[4] == dcts_pkg::SZ_16_WORDS)
    else $error("cascade channel settings changed");
  chk_reset_compat: assert property (
    @(posedge sys_clk) disable iff (1'b0) reset |=> timing_sel == '0)
    else $error("timing not compatible after reset");
  chk_done_pulse: assert property (
    cyc_done |=> !cyc_done)
    else $error("done pulse longer than one cycle");
  chk_cmd_stands: assert property (
    cyc_busy && $past(cyc_busy) |-> $stable(cyc_cmd))
    else $error("command changed during cycle");
  chk_compat_len: assert property (
    cyc_busy && cyc_cmd.timing == dcts_pkg::TM_COMPAT |-> cyc_cmd.io == 4'h3 &&
    cyc_cmd.total inside {4'h9, 4'h8})
    else $error("compatible cycle length wrong");
  chk_type_a_len: assert property (
    cyc_busy && cyc_cmd.timing == dcts_pkg::TM_TYPE_A |-> cyc_cmd.io == 4'h3 &&
    cyc_cmd.total inside {4'h7, 4'h6})
    else $error("type A cycle length wrong");
  chk_type_b_len: assert property (
    cyc_busy && cyc_cmd.timing == dcts_pkg::TM_TYPE_B |-> cyc_cmd.total inside {4'h6, 4'h4})
    else $error("type B cycle length wrong");
  chk_burst_len: assert property (
    cyc_busy && cyc_cmd.timing == dcts_pkg::TM_BURST |-> cyc_cmd.total inside {4'h1, 4'h2})
    else $error("burst cycle length wrong");
  chk_io_inside: assert property (
    @(posedge bclk) disable iff (reset) bus_io_phase |-> bus_cyc_active)
    else $error("I/O portion outside bus cycle");
endmodule
bind dcts_top dcts_monitor u_mon (.sys_clk, .reset, .bclk, .emr_wr, .emr_hi_group,
  .emr_wr_data, .timing_sel, .size_sel, .cyc_busy, .cyc_done, .cyc_cmd,
  .bus_cyc_active, .bus_io_phase);
`default_nettype wire

// >>> tb/dcts_slave_model.sv
// Far side slave: times each bus cycle and its I/O portion
`timescale 1ns/1ps
`default_nettype none
module dcts_slave_model (
  input wire logic bclk, // Bus clock
  input wire logic bus_cyc_active, // Cycle running
  input wire logic bus_io_phase, // I/O portion
  output logic [3:0] len_seen, // Clocks of last cycle
  output logic [3:0] io_seen // I/O clocks of last cycle
);
  logic [3:0] run_r = 4'h0;
  logic [3:0] io_r = 4'h0;
  // Slave paces data by the active and I/O strobes only
  always @(posedge bclk) begin
    if (bus_cyc_active === 1'b1) begin
      run_r <= run_r + 4'h1;
      io_r <= io_r + ((bus_io_phase === 1'b1) ? 4'h1 : 4'h0);
    end else if (run_r != 4'h0) begin
      len_seen <= run_r;
      io_seen <= io_r;
      run_r <= 4'h0;
      io_r <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the timing selection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic bclk = 1'b0;
  logic reset = 1'b1;
  logic emr_wr = 1'b0;
  logic emr_hi_group = 1'b0;
  logic [7:0] emr_wr_data = 8'h00;
  logic req_valid = 1'b0;
  dcts_pkg::dcts_req_type req = '0;
  dcts_pkg::dcts_req_type r;
  dcts_pkg::dcts_cmd_type cyc_cmd, e;
  logic [7:0][1:0] timing_sel, size_sel;
  logic req_ready, cyc_busy, cyc_done, bus_cyc_active, bus_io_phase, lock;
  logic [3:0] bus_lanes, len_seen, io_seen;
  logic [1:0] bus_timing;
  logic [1:0] tm_m [8];
  logic [1:0] sz_m [8];
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int dones = 0;
  int seed = 32'h291f;
  int i, k, d;
  // Clocks: bus clock offset so edges never meet
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    #1.3;
    forever #62.5 bclk = ~bclk;
  end
  dcts_top dut (.sys_clk, .reset, .bclk, .emr_wr, .emr_hi_group, .emr_wr_data, .req_valid,
    .req_ready, .req, .timing_sel, .size_sel, .cyc_busy, .cyc_done, .cyc_cmd,
    .bus_cyc_active, .bus_io_phase, .bus_lanes, .bus_timing);
  dcts_slave_model far (.bclk, .bus_cyc_active, .bus_io_phase, .len_seen, .io_seen);
  // Cycle ceiling and completion count
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cyc_done === 1'b1)
      dones <= dones + 1;
    if (cycles == 40000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (exp !== got) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp_sel(input string what);
    for (int j = 0; j < 8; j++) begin
      check({what, " timing"}, tm_m[j], timing_sel[j]);
      check({what, " size"}, sz_m[j], size_sel[j]);
    end
  endtask
  task automatic emr(input logic [2:0] ch, input logic [1:0] tm, input logic [1:0] sz);
    emr_wr = 1'b1;
    emr_hi_group = ch[2];
    emr_wr_data = {2'($random(seed)), tm, sz, ch[1:0]};
    tick;
    emr_wr = 1'b0;
    // Let an edge pass so back to back writes never share a time step
    tick;
    if (ch != 3'h4) begin
      tm_m[ch] = tm;
      sz_m[ch] = sz;
    end
  endtask
  // Expected command from selector, size and request
  function automatic dcts_pkg::dcts_cmd_type exp_cmd(input logic [1:0] tm,
      input logic [1:0] sz, input dcts_pkg::dcts_req_type q, input logic lk);
    dcts_pkg::dcts_cmd_type c;
    c.timing = q.isa_mem ? 2'h0 : tm;
    c.io = (c.timing == 2'h2) ? 4'h2 : (c.timing == 2'h3) ? 4'h1 : 4'h3;
    case (c.timing)
      2'h0: c.total = q.rpt ? 4'h8 : 4'h9;
      2'h1: c.total = q.rpt ? 4'h6 : 4'h7;
      2'h2: c.total = q.rpt ? 4'h4 : 4'h6;
      default: c.total = (lk || !q.burst_mem) ? 4'h2 : 4'h1;
    endcase
    c.lanes = (sz == 2'h0) ? 4'h1 : (sz == 2'h2) ? 4'hf : 4'h3;
    return c;
  endfunction
  task automatic push(input dcts_pkg::dcts_req_type q);
    req = q;
    req_valid = 1'b1;
    while (req_ready !== 1'b1)
      tick;
    tick;
  endtask
  task automatic run_one(input dcts_pkg::dcts_req_type q);
    int n;
    n = dones;
    if (q.first)
      lock = !q.burst_mem;
    e = exp_cmd(tm_m[q.ch], sz_m[q.ch], q, lock);
    push(q);
    req_valid = 1'b0;
    while (dones == n)
      tick;
    // Far side records the cycle one bus clock after it ends
    repeat (30) tick;
    check("cmd timing", e.timing, cyc_cmd.timing);
    check("cmd total", e.total, cyc_cmd.total);
    check("cmd lanes", e.lanes, cyc_cmd.lanes);
    check("bus length", e.total, len_seen);
    check("bus timing", e.timing, bus_timing);
    check("bus lanes", e.lanes, bus_lanes);
    if (e.timing != 2'h3)
      check("io length", e.io, io_seen);
  endtask
  initial begin
    repeat (80) tick;
    reset = 1'b0;
    repeat (100) tick;
    for (i = 0; i < 8; i++) begin
      tm_m[i] = 2'h0;
      sz_m[i] = (i >= 4) ? 2'h1 : 2'h0;
    end
    cmp_sel("reset");
    $display("test reset_values done");
    // Random codes, then every code in turn; cascade write ignored
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 8; i++) begin
        emr(3'(i), k ? 2'(i) : 2'($random(seed)), 2'($random(seed)));
        cmp_sel("write");
      end
    end
    $display("test extended_mode done");
    for (i = 0; i < 40; i++) begin
      r = dcts_pkg::dcts_req_type'(7'($random(seed)));
      r.first = 1'b1;
      run_one(r);
    end
    $display("test random_cycles done");
    // Burst channel: start non-burst, cross into burst memory, and back
    for (i = 0; i < 4; i++) begin
      r = '0;
      r.ch = 3'h3;
      r.first = !i[0];
      r.burst_mem = i[0] ^ i[1];
      run_one(r);
    end
    $display("test burst_lock done");
    // Queue fills until refused, then drains
    d = dones;
    r = '0;
    r.ch = 3'h1;
    r.first = 1'b1;
    repeat (5) push(r);
    check("ready when full", 1'b0, req_ready);
    req_valid = 1'b0;
    while (dones < d + 5)
      tick;
    check("ready when drained", 1'b1, req_ready);
    $display("test queue_fill done");
    test_done();
  end
endmodule
`default_nettype wire
